/* inc/ggopi_defines.vh */
// How it works
// [R01] gang control takes first write only
// [R02] bit0 enables gang, bits 7:1 select pins
// [R03] ganged pins output, copy master data/drive/slew
// [R04] slots 7:4 port B 5:2, 3:1 port C 3:1
// [R05] gang enable forces master pin to output
// [R06] analog beats gang, gang beats peripheral
// [R07] irq pins A3:0, B3:0, also wake-up
// [R08] per-pin interrupt enable bit
// [R09] per-port mode: edge or edge-and-level
// [R10] per-pin polarity: fall/low or rise/high
// [R11] pull type from edge select bit
// [R12] falling edge: sample 1 then 0
// [R13] rising edge: sample 0 then 1
// [R14] edge only after deasserted level seen
// [R15] edge sets flag; enable raises request
// [R16] edge mode: acknowledge clears flag
// [R17] edge mode: no latch while another asserted
// [R18] asserted pin state readable by software
// [R19] level mode: ack clears only when idle
// [R20] software follows the init order
// [R21] acknowledge clears spurious enable flag
// [R22] software checks power-down flag after stop2
// [R23] stop3 keeps all state unchanged
// [R24] writing ack clears power-down flag
// [R25] request high while flag and enable set
`ifndef GGOPI_DEFINES_VH
`define GGOPI_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define GGOPI_OFS_GANG 8'h00
`define GGOPI_OFS_SC_A 8'h04
`define GGOPI_OFS_PS_A 8'h08
`define GGOPI_OFS_ES_A 8'h0C
`define GGOPI_OFS_PE_A 8'h10
`define GGOPI_OFS_SC_B 8'h14
`define GGOPI_OFS_PS_B 8'h18
`define GGOPI_OFS_ES_B 8'h1C
`define GGOPI_OFS_PE_B 8'h20
`define GGOPI_OFS_PMSC 8'h24
`define GGOPI_OFS_PINS 8'h28

// ----------------------------------------
// field positions
// ----------------------------------------
`define GGOPI_SC_MODE 0
`define GGOPI_SC_IE 1
`define GGOPI_SC_ACK 2
`define GGOPI_SC_FLAG 3
`define GGOPI_PM_ACK 2
`define GGOPI_PM_FLAG 3
`define GGOPI_GANG_EN 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define GGOPI_RST_GANG 8'h00
`define GGOPI_RST_NIB 4'h0

`endif

/* design/ggopi_port_ctrl.v */
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "ggopi_defines.vh"

module ggopi_port_ctrl (
   input wire clock, // bus clock, 20 MHz
   input wire rstn, // async reset, active low
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   // gang slots: 0 master, 3:1 port c 3:1, 7:4 port b 5:2
   input wire [7:0] gpio_dir, // direction bits of slot pins
   input wire [7:0] gpio_data, // data bits of slot pins
   input wire [7:0] gpio_drive, // drive bits of slot pins
   input wire [7:0] gpio_slew, // slew bits of slot pins
   input wire [7:0] periph_en, // shared digital function on
   input wire [7:0] periph_oe, // its output enable
   input wire [7:0] periph_out, // its output value
   input wire [7:0] analog_en, // analog function on
   output reg [7:0] slot_oe, // output buffer enable
   output reg [7:0] slot_out, // output value
   output reg [7:0] slot_drive, // high drive select
   output reg [7:0] slot_slew, // slew limit select
   output reg [7:0] slot_gang, // slot under gang control
   // interrupt pins: 3:0 port a 3:0, 7:4 port b 3:0
   input wire [7:0] irq_pin_in, // raw pin levels
   output reg [7:0] irq_pull_up, // pull-up on
   output reg [7:0] irq_pull_down, // pull-down on
   output reg [1:0] irq_req, // request per port, b a
   output reg wake_req, // wake from stop3 or wait
   // power management
   input wire stop2_recovered // pulse on stop2 wake
);

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire setup_ph = psel & ~penable; // first cycle
   wire access_ph = psel & penable; // second cycle
   wire wr_en = access_ph & pwrite; // write takes effect

   // mapped offset check
   function hit_map;
      input [7:0] a;
      begin
         hit_map = (a[1:0] == 2'b00) && (a <= `GGOPI_OFS_PINS);
      end
   endfunction

   // write strobe for one offset
   function wr_at;
      input en;
      input [7:0] a;
      input [7:0] ofs;
      begin
         wr_at = en && (a == ofs);
      end
   endfunction

   assign pready = 1'b1; // no wait states
   assign pslverr = access_ph & ~hit_map(paddr); // unmapped

   // ----------------------------------------
   // register state
   // ----------------------------------------
   reg [7:0] gang_ff; // gang control register
   reg gang_done_ff; // first write seen
   reg [1:0] mode_ff; // detect mode per port
   reg [1:0] ie_ff; // irq enable per port
   reg [1:0] flag_ff; // irq flag per port
   reg [7:0] ps_ff; // pin select, b:a
   reg [7:0] es_ff; // edge select, b:a
   reg [7:0] pe_ff; // pull enable, b:a
   reg ppd_ff; // partial power-down flag
   reg [1:0] ack_w; // acknowledge write per port
   reg [1:0] nxt_flag; // next flags

   wire gang_wr = wr_at(wr_en, paddr, `GGOPI_OFS_GANG);
   wire sca_wr = wr_at(wr_en, paddr, `GGOPI_OFS_SC_A);
   wire scb_wr = wr_at(wr_en, paddr, `GGOPI_OFS_SC_B);
   wire pm_wr = wr_at(wr_en, paddr, `GGOPI_OFS_PMSC);

   // acknowledge bits, write-one strobes
   always @* begin
      ack_w[0] = sca_wr & pwdata[`GGOPI_SC_ACK]; // [R16] [R21]
      ack_w[1] = scb_wr & pwdata[`GGOPI_SC_ACK]; // [R16] [R21]
   end

   // ----------------------------------------
   // gang control, write once
   // ----------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gang_ff <= `GGOPI_RST_GANG;
         gang_done_ff <= 1'b0;
      end else if (gang_wr && !gang_done_ff) begin
         gang_ff <= pwdata[7:0]; // [R01]
         gang_done_ff <= 1'b1; // later writes dropped [R01]
      end
   end

   // ----------------------------------------
   // pin interrupt config registers
   // ----------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mode_ff <= 2'b00;
         ie_ff <= 2'b00;
         ps_ff <= 8'h00;
         es_ff <= 8'h00;
         pe_ff <= 8'h00;
      end else begin
         // status and control, port a
         if (sca_wr) begin
            mode_ff[0] <= pwdata[`GGOPI_SC_MODE]; // [R09]
            ie_ff[0] <= pwdata[`GGOPI_SC_IE];
         end
         // status and control, port b
         if (scb_wr) begin
            mode_ff[1] <= pwdata[`GGOPI_SC_MODE]; // [R09]
            ie_ff[1] <= pwdata[`GGOPI_SC_IE];
         end
         // per-pin selects
         if (wr_at(wr_en, paddr, `GGOPI_OFS_PS_A))
            ps_ff[3:0] <= pwdata[3:0]; // [R08]
         if (wr_at(wr_en, paddr, `GGOPI_OFS_PS_B))
            ps_ff[7:4] <= pwdata[3:0]; // [R08]
         // per-pin polarity
         if (wr_at(wr_en, paddr, `GGOPI_OFS_ES_A))
            es_ff[3:0] <= pwdata[3:0]; // [R10]
         if (wr_at(wr_en, paddr, `GGOPI_OFS_ES_B))
            es_ff[7:4] <= pwdata[3:0]; // [R10]
         // pull enables
         if (wr_at(wr_en, paddr, `GGOPI_OFS_PE_A))
            pe_ff[3:0] <= pwdata[3:0];
         if (wr_at(wr_en, paddr, `GGOPI_OFS_PE_B))
            pe_ff[7:4] <= pwdata[3:0];
      end
   end

   // ----------------------------------------
   // pin synchronisers and filter
   // ----------------------------------------
   reg [7:0] sync1_ff; // first stage, read by second only
   reg [7:0] sync2_ff; // second stage
   reg [7:0] sync3_ff; // third stage
   reg [7:0] lvl_ff; // accepted pin level

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync1_ff <= 8'h00;
         sync2_ff <= 8'h00;
         sync3_ff <= 8'h00;
         lvl_ff <= 8'h00;
      end else begin
         sync1_ff <= irq_pin_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         // change counts once stages two and three agree
         lvl_ff <= (sync2_ff & sync3_ff) | (lvl_ff & (sync2_ff | sync3_ff));
      end
   end

   // ----------------------------------------
   // assertion and edge detection per pin
   // ----------------------------------------
   wire [7:0] asserted; // enabled and at asserted level
   reg [7:0] prev_ff; // last sample, disabled pins read 1
   wire [7:0] edge_hit; // valid edge this cycle
   wire [7:0] edge_ok; // edge allowed to latch

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : pin
         // polarity: es 0 falling/low, 1 rising/high
         assign asserted[g] = ps_ff[g] & (es_ff[g] ? lvl_ff[g] : ~lvl_ff[g]); // [R10] [R07]
         // sample each cycle; deasserted must be seen first
         assign edge_hit[g] = asserted[g] & ~prev_ff[g]; // [R12] [R13] [R14]
         // another enabled pin of the port already asserted
         assign edge_ok[g] = edge_hit[g] &
            ~(|(prev_ff[(g/4)*4 +: 4] & ps_ff[(g/4)*4 +: 4] & ~(4'h1 << (g%4)))); // [R17]
      end
   endgenerate

   always @(posedge clock or negedge rstn) begin
      if (!rstn)
         prev_ff <= 8'hFF;
      else
         prev_ff <= asserted | ~ps_ff; // [R14]
   end

   // ----------------------------------------
   // port flags
   // ----------------------------------------
   always @* begin
      nxt_flag = flag_ff;
      // port a: set wins over acknowledge
      if (mode_ff[0])
         nxt_flag[0] = (|asserted[3:0]) | (flag_ff[0] & ~ack_w[0]); // [R19]
      else
         nxt_flag[0] = (|edge_ok[3:0]) | (flag_ff[0] & ~ack_w[0]); // [R15] [R16]
      // port b
      if (mode_ff[1])
         nxt_flag[1] = (|asserted[7:4]) | (flag_ff[1] & ~ack_w[1]); // [R19]
      else
         nxt_flag[1] = (|edge_ok[7:4]) | (flag_ff[1] & ~ack_w[1]); // [R15] [R16]
   end

   // flag, request and wake registers
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flag_ff <= 2'b00;
         irq_req <= 2'b00;
         wake_req <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
         irq_req <= nxt_flag & ie_ff; // [R15] [R25]
         wake_req <= |(nxt_flag & ie_ff); // [R07]
      end
   end

   // ----------------------------------------
   // pull resistor selection
   // ----------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_pull_up <= 8'h00;
         irq_pull_down <= 8'h00;
      end else begin
         irq_pull_up <= pe_ff & ~es_ff; // [R11]
         irq_pull_down <= pe_ff & es_ff; // [R11]
      end
   end

   // ----------------------------------------
   // partial power-down flag
   // ----------------------------------------
   always @(posedge clock or negedge rstn) begin
      if (!rstn)
         ppd_ff <= 1'b0;
      else if (stop2_recovered)
         ppd_ff <= 1'b1; // set wins over acknowledge
      else if (pm_wr && pwdata[`GGOPI_PM_ACK])
         ppd_ff <= 1'b0; // [R24]
   end

   // ----------------------------------------
   // gang output steering
   // ----------------------------------------
   wire gang_on = gang_ff[`GGOPI_GANG_EN]; // [R02]
   // master follows enable, others need their select too
   wire [7:0] gang_sel = {gang_ff[7:1], 1'b1} & {8{gang_on}}; // [R02] [R04] [R05]

   generate
      for (g = 0; g < 8; g = g + 1) begin : slot
         // analog first, then gang, then peripheral, then gpio
         always @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               slot_oe[g] <= 1'b0;
               slot_out[g] <= 1'b0;
               slot_drive[g] <= 1'b0;
               slot_slew[g] <= 1'b0;
               slot_gang[g] <= 1'b0;
            end else if (analog_en[g]) begin
               slot_oe[g] <= 1'b0; // [R06]
               slot_out[g] <= 1'b0;
               slot_drive[g] <= gpio_drive[g];
               slot_slew[g] <= gpio_slew[g];
               slot_gang[g] <= 1'b0;
            end else if (gang_sel[g]) begin
               slot_oe[g] <= 1'b1; // [R03] [R05] [R06]
               slot_out[g] <= gpio_data[0]; // [R03]
               slot_drive[g] <= gpio_drive[0]; // [R03]
               slot_slew[g] <= gpio_slew[0]; // [R03]
               slot_gang[g] <= 1'b1;
            end else if (periph_en[g]) begin
               slot_oe[g] <= periph_oe[g];
               slot_out[g] <= periph_out[g];
               slot_drive[g] <= gpio_drive[g];
               slot_slew[g] <= gpio_slew[g];
               slot_gang[g] <= 1'b0;
            end else begin
               slot_oe[g] <= gpio_dir[g];
               slot_out[g] <= gpio_data[g];
               slot_drive[g] <= gpio_drive[g];
               slot_slew[g] <= gpio_slew[g];
               slot_gang[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // read data, captured in setup phase
   // ----------------------------------------
   reg [31:0] rd_mux; // read value for paddr

   always @* begin
      case (paddr)
         `GGOPI_OFS_GANG: rd_mux = {24'h000000, gang_ff};
         `GGOPI_OFS_SC_A: rd_mux = {28'h0000000, flag_ff[0], 1'b0, ie_ff[0], mode_ff[0]};
         `GGOPI_OFS_SC_B: rd_mux = {28'h0000000, flag_ff[1], 1'b0, ie_ff[1], mode_ff[1]};
         `GGOPI_OFS_PS_A: rd_mux = {28'h0000000, ps_ff[3:0]};
         `GGOPI_OFS_PS_B: rd_mux = {28'h0000000, ps_ff[7:4]};
         `GGOPI_OFS_ES_A: rd_mux = {28'h0000000, es_ff[3:0]};
         `GGOPI_OFS_ES_B: rd_mux = {28'h0000000, es_ff[7:4]};
         `GGOPI_OFS_PE_A: rd_mux = {28'h0000000, pe_ff[3:0]};
         `GGOPI_OFS_PE_B: rd_mux = {28'h0000000, pe_ff[7:4]};
         `GGOPI_OFS_PMSC: rd_mux = {28'h0000000, ppd_ff, 3'h0};
         `GGOPI_OFS_PINS: rd_mux = {16'h0000, asserted, lvl_ff}; // [R18]
         default: rd_mux = 32'h00000000;
      endcase
   end

   // flags are cleared only by reset or acknowledge writes, so stop3 keeps them
   always @(posedge clock or negedge rstn) begin
      if (!rstn)
         prdata <= 32'h00000000; // [R23]
      else if (setup_ph)
         prdata <= rd_mux;
   end

endmodule

/* tb/ggopi_port_ctrl_sva.sv */
`timescale 1ns/100ps
// ------------------------------
// port checker
// ------------------------------
module ggopi_port_ctrl_sva (
   input wire clock,
   input wire rstn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire [7:0] gpio_data,
   input wire [7:0] gpio_drive,
   input wire [7:0] analog_en,
   input wire [7:0] slot_oe,
   input wire [7:0] slot_out,
   input wire [7:0] slot_drive,
   input wire [7:0] slot_gang,
   input wire [7:0] irq_pull_up,
   input wire [7:0] irq_pull_down,
   input wire [1:0] irq_req,
   input wire wake_req
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   a_pready_high: assert property (pready)
      else $error("pready low");
   a_slverr_unmapped: assert property (psel && penable && (paddr > 8'h28 ||
      paddr[1:0] != 2'b00) |-> pslverr) else $error("no error on bad address");
   a_wake_tracks: assert property (wake_req == |irq_req)
      else $error("wake differs from requests");
   a_pull_exclusive: assert property ((irq_pull_up & irq_pull_down) == 8'h00)
      else $error("pull-up and pull-down together");
   a_master_forced: assert property (slot_gang[0] && !$past(analog_en[0]) |-> slot_oe[0])
      else $error("master not output");
   a_gang_copies: assert property (slot_gang != 8'h00 |-> ((slot_out ^
      {8{$past(gpio_data[0])}}) & slot_gang & ~$past(analog_en)) == 8'h00)
      else $error("ganged data differs from master");
   a_gang_drive: assert property (slot_gang != 8'h00 |-> ((slot_drive ^
      {8{$past(gpio_drive[0])}}) & slot_gang & ~$past(analog_en)) == 8'h00)
      else $error("ganged drive differs from master");
   a_analog_wins: assert property ((slot_oe & $past(analog_en)) == 8'h00)
      else $error("analog slot drives");
   a_select_needs_en: assert property (slot_gang[7:1] != 7'h00 &&
      !$past(analog_en[0]) |-> slot_gang[0]) else $error("gang without enable");
   a_req_holds: assert property ($fell(irq_req[0]) |->
      $past(psel && penable && pwrite && paddr == 8'h04)) else $error("request dropped");
endmodule

/* tb/ggopi_pin_model.sv */
`timescale 1ns/100ps
// ------------------------------
// external pins with pulls
// ------------------------------
module ggopi_pin_model (
   input wire clock,
   input wire [7:0] pull_up,
   input wire [7:0] pull_down,
   input wire [7:0] drv_en,
   input wire [7:0] drv_val,
   output wire [7:0] pins
);
   reg [7:0] float_ff; // undriven lines wander
   initial float_ff = 8'h55;
   // toggle each cycle
   always @(posedge clock) begin
      float_ff <= ~float_ff;
   end
   // driver beats pulls, pulls beat float
   assign pins = (drv_en & drv_val) | (~drv_en & pull_up)
      | (~drv_en & ~pull_up & ~pull_down & float_ff);
endmodule

/* tb/gpio_ganged_output_pin_interrupt_test.sv */
`timescale 1ns/100ps
module gpio_ganged_output_pin_interrupt_test;
   reg clock, rstn, psel, penable, pwrite, stop2_recovered, err;
   reg [7:0] paddr, gpio_dir, gpio_data, gpio_drive, gpio_slew;
   reg [7:0] periph_en, periph_oe, periph_out, analog_en, drv_en, drv_val;
   reg [31:0] pwdata, rd;
   wire pready, pslverr, wake_req;
   wire [31:0] prdata;
   wire [7:0] slot_oe, slot_out, slot_drive, slot_slew, slot_gang;
   wire [7:0] irq_pin_in, irq_pull_up, irq_pull_down;
   wire [1:0] irq_req;
   integer n_mismatch, compares, i;
   always #25 clock = ~clock;
   ggopi_port_ctrl i_ggopi_port_ctrl (.clock(clock), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .gpio_dir(gpio_dir),
      .gpio_data(gpio_data), .gpio_drive(gpio_drive), .gpio_slew(gpio_slew),
      .periph_en(periph_en), .periph_oe(periph_oe), .periph_out(periph_out),
      .analog_en(analog_en), .slot_oe(slot_oe), .slot_out(slot_out),
      .slot_drive(slot_drive), .slot_slew(slot_slew), .slot_gang(slot_gang),
      .irq_pin_in(irq_pin_in), .irq_pull_up(irq_pull_up),
      .irq_pull_down(irq_pull_down), .irq_req(irq_req), .wake_req(wake_req),
      .stop2_recovered(stop2_recovered));
   ggopi_pin_model i_ggopi_pin_model (.clock(clock), .pull_up(irq_pull_up),
      .pull_down(irq_pull_down), .drv_en(drv_en), .drv_val(drv_val), .pins(irq_pin_in));
   // ------------------------------
   // helpers
   // ------------------------------
   task summarize;
      begin
         $display("compares %0d n_mismatch %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one apb transfer, held until pready
   task apb(input [7:0] a, input w, input [31:0] d);
      begin
         @(posedge clock);
         psel <= 1'b1;
         paddr <= a;
         pwrite <= w;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         @(posedge clock);
         while (pready !== 1'b1) @(posedge clock);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task rchk(input [7:0] a, input [31:0] e);
      begin
         apb(a, 1'b0, 32'h0);
         check(rd, e);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clock);
   endtask
   // bounded wait for a request level
   task wait_req(input integer k, input v);
      begin
         i = 0;
         while (irq_req[k] !== v && i < 20) begin
            @(posedge clock);
            i = i + 1;
         end
         check(irq_req[k], v);
      end
   endtask
   // ------------------------------
   // watchdog
   // ------------------------------
   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch = n_mismatch + 1;
      summarize;
   end
   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      {clock, rstn, psel, penable, pwrite, stop2_recovered, err} = 7'h00;
      {paddr, gpio_dir, gpio_data, gpio_drive, gpio_slew} = 40'h0;
      {periph_en, periph_oe, periph_out, analog_en, drv_en, drv_val} = 48'h0;
      pwdata = 32'h0;
      n_mismatch = 0;
      compares = 0;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      rchk(8'h00, 32'h0);
      rchk(8'h04, 32'h0);
      rchk(8'h24, 32'h0);
      rchk(8'h2C, 32'h0);
      check(err, 1'b1);
      // gang: master, slot1 over a peripheral, slot4 analog
      gpio_data <= 8'h01;
      gpio_drive <= 8'h01;
      gpio_slew <= 8'h01;
      periph_en <= 8'h02;
      analog_en <= 8'h10;
      wr(8'h00, 32'h13);
      wr(8'h00, 32'hFF);
      rchk(8'h00, 32'h13);
      cyc(2);
      check(slot_oe, 8'h03);
      check(slot_out & 8'h03, 8'h03);
      check(slot_drive & 8'h03, 8'h03);
      check(slot_slew & 8'h03, 8'h03);
      check(slot_gang, 8'h03);
      gpio_data <= 8'h00;
      cyc(2);
      check(slot_out & 8'h03, 8'h00);
      // pull type from polarity
      wr(8'h0C, 32'h5);
      wr(8'h10, 32'hF);
      cyc(2);
      check(irq_pull_up & 8'h0F, 8'h0A);
      check(irq_pull_down & 8'h0F, 8'h05);
      // port a falling edge, init order
      drv_en <= 8'hFF;
      drv_val <= 8'hFF;
      wr(8'h04, 32'h0);
      wr(8'h0C, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h08, 32'h1);
      cyc(6);
      wr(8'h04, 32'h4);
      wr(8'h04, 32'h2);
      cyc(6);
      check(irq_req, 2'b00);
      drv_val <= 8'hFE;
      wait_req(0, 1'b1);
      check(wake_req, 1'b1);
      rchk(8'h04, 32'h0A);
      apb(8'h28, 1'b0, 32'h0);
      check(rd[8], 1'b1);
      wr(8'h04, 32'h6);
      cyc(1);
      check(irq_req[0], 1'b0);
      rchk(8'h04, 32'h02);
      // second pin falls while first asserted
      wr(8'h08, 32'h3);
      cyc(6);
      drv_val <= 8'hFC;
      cyc(12);
      check(irq_req[0], 1'b0);
      // level mode: ack refused while asserted
      wr(8'h04, 32'h3);
      wait_req(0, 1'b1);
      wr(8'h04, 32'h7);
      cyc(1);
      rchk(8'h04, 32'h0B);
      drv_val <= 8'hFF;
      cyc(8);
      wr(8'h04, 32'h7);
      cyc(1);
      check(irq_req[0], 1'b0);
      // port b rising edge
      drv_val <= 8'hEF;
      wr(8'h1C, 32'h1);
      wr(8'h18, 32'h1);
      cyc(6);
      wr(8'h14, 32'h6);
      cyc(6);
      check(irq_req[1], 1'b0);
      drv_val <= 8'hFF;
      wait_req(1, 1'b1);
      wr(8'h14, 32'h6);
      cyc(1);
      check(irq_req, 2'b00);
      // re-enabled while asserted: no edge
      wr(8'h18, 32'h0);
      wr(8'h18, 32'h1);
      cyc(10);
      check(irq_req[1], 1'b0);
      // stop2 recovery flag
      stop2_recovered <= 1'b1;
      cyc(1);
      stop2_recovered <= 1'b0;
      rchk(8'h24, 32'h08);
      wr(8'h24, 32'h04);
      rchk(8'h24, 32'h0);
      rchk(8'h00, 32'h13);
      // mid-run reset re-arms the write-once gang register
      rstn <= 1'b0;
      cyc(2);
      rstn <= 1'b1;
      rchk(8'h00, 32'h0);
      wr(8'h00, 32'h01);
      rchk(8'h00, 32'h01);
      summarize;
   end
endmodule
bind ggopi_port_ctrl ggopi_port_ctrl_sva i_ggopi_port_ctrl_sva (.clock(clock),
   .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .gpio_data(gpio_data),
   .gpio_drive(gpio_drive), .analog_en(analog_en), .slot_oe(slot_oe),
   .slot_out(slot_out), .slot_drive(slot_drive), .slot_gang(slot_gang),
   .irq_pull_up(irq_pull_up), .irq_pull_down(irq_pull_down),
   .irq_req(irq_req), .wake_req(wake_req));
